// File: rtl/sfsr_pkg.sv
/*
  sfsr_pkg: constants, status layout, pin bundle and states of the
  serial flash status register block.
  assumes: shared by sfsr_top and sfsr_top_test; no other dependency.
*/
package sfsr_pkg;

  // opcodes seen by this block
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;

  // status bit positions
  localparam int BIT_LOCK = 7;
  localparam int BIT_SEQ = 6;
  localparam int BIT_ERR = 5;
  localparam int BIT_PIN = 4;
  localparam int BIT_SWP_HI = 3;
  localparam int BIT_SWP_LO = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_BUSY = 0;

  // reset values
  localparam logic RST_LOCK = 1'h0;
  localparam logic RST_ERR = 1'h0;
  localparam logic RST_WEL = 1'h0;
  localparam logic [1:0] RST_SWP = 2'h3;

  // protection summary codes
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL = 2'h3;

  // bit counter limits
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // status byte, bit 7 first
  typedef struct packed {
    logic lock;
    logic seq_mode;
    logic prog_err;
    logic pin_state;
    logic [1:0] sw_protect_summary;
    logic write_enable_latch;
    logic busy;
  } sfsr_status_t;

  // raw pins: select, serial clock, serial in, write-protect
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } sfsr_pins_t;

  typedef enum {
    ST_IDLE,
    ST_OPCODE,
    ST_STATUS,
    ST_WRDATA,
    ST_IGNORE
  } sfsr_state_t;

endpackage : sfsr_pkg

// File: rtl/sfsr_sync.sv
/*
  sfsr_sync: two flip-flop synchroniser for a bundle of pin levels.
  assumes: inputs are asynchronous levels; the first stage is read
  only by the second.
*/
`timescale 1ns/1ps

module sfsr_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // reset to idle pin levels: select and write-protect high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '1;
      q_ff <= '1;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : sfsr_sync

// File: rtl/sfsr_top.sv
/*
  sfsr_top: status register of a serial flash with its spi slave
  front end for read-status and write-status, modes 0 and 3.
  assumes: the device core drives busy, mode, protection summary and
  completion events on core_clk; spi pins are asynchronous and much
  slower than core_clk (at least 4 core cycles per sck phase).
*/
`timescale 1ns/1ps

// How it works
// - read-status opcode starts output on next clocks
// - msb first, wraps from bit 0 to 7
// - every repeated byte is sampled anew
// - read-status accepted even while busy
// - select release ends read, output floats
// - only bit 7 lock is software writable
// - lock set blocks sector protect commands
// - lock clears after reset
// - pin asserted lets lock go only 0 to 1
// - bit 6 shows sequential program mode
// - bit 5 error refreshed per program/erase
// - aborted operation leaves error bit alone
// - bit 4 mirrors write-protect pin
// - bits 3:2 give none/some/all protected
// - latch clear rejects write-type commands
// - write-enable latch clears after reset
// - latch auto-clears on listed completions/aborts
// - incomplete opcode leaves latch set
// - bit 0 shows busy
// - opcode 01h plus byte writes lock
module sfsr_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // spi and write-protect pins
  input wire sfsr_pkg::sfsr_pins_t pins,
  output logic so_out,
  output logic so_oe,
  // device core status
  input wire logic core_busy,
  input wire logic core_seq_mode,
  input wire logic core_any_protected,
  input wire logic core_all_protected,
  input wire logic op_done,
  input wire logic op_failed,
  input wire logic wel_set,
  input wire logic wel_clear,
  // towards device core
  output sfsr_pkg::sfsr_status_t status,
  output logic [7:0] cmd_opcode,
  output logic cmd_strobe,
  output logic write_cmd_enable,
  output logic sector_cmd_enable
);

  sfsr_pkg::sfsr_pins_t pins_s;
  sfsr_pkg::sfsr_state_t state_ff;
  sfsr_pkg::sfsr_state_t nxt_state;
  sfsr_pkg::sfsr_status_t status_ff;
  sfsr_pkg::sfsr_status_t snap_ff;
  logic sck_d_ff;
  logic cs_act_d_ff;
  logic [2:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] opc_ff;
  logic opc_full_ff;
  logic data_full_ff;
  logic new_lock_ff;
  logic [2:0] ptr_ff;
  logic so_ff;
  logic oe_ff;
  logic strobe_ff;
  logic lock_ff;
  logic err_ff;
  logic wel_ff;
  logic [1:0] swp_ff;
  logic nxt_wel;
  logic nxt_lock;
  logic [1:0] nxt_swp;

  // pins pass two flops before any logic looks at them
  sfsr_sync #(
    .W(4)
  ) u_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .d(pins),
    .q(pins_s)
  );

  // decode of synchronised pins
  wire cs_act = ~pins_s.cs_n;
  wire sck_rise = pins_s.sck & ~sck_d_ff;
  wire sck_fall = ~pins_s.sck & sck_d_ff;
  wire cs_end = cs_act_d_ff & ~cs_act;
  wire wp_asserted = ~pins_s.wp_n;
  wire [7:0] shift_in = {shift_ff[6:0], pins_s.si};
  wire in_opcode = cs_act & ((state_ff == sfsr_pkg::ST_IDLE) |
                             (state_ff == sfsr_pkg::ST_OPCODE));
  wire opc_last = in_opcode & sck_rise & (cnt_ff == sfsr_pkg::LAST_BIT);
  wire data_last = cs_act & (state_ff == sfsr_pkg::ST_WRDATA) & sck_rise &
                   (cnt_ff == sfsr_pkg::LAST_BIT);
  wire in_status = cs_act & (state_ff == sfsr_pkg::ST_STATUS);
  wire shift_out = in_status & sck_fall;
  wire wr_status_end = cs_end & opc_full_ff &
                       (opc_ff == sfsr_pkg::OPC_WRITE_STATUS);
  // pin asserted: lock may not go from 1 back to 0
  wire lock_blocked = wp_asserted & lock_ff & ~new_lock_ff;
  wire lock_write_ok = wel_ff & data_full_ff & ~lock_blocked;
  // live byte for bit 7, snapshot for the rest of the same byte
  wire out_bit = (ptr_ff == sfsr_pkg::LAST_BIT) ? status_ff[ptr_ff] :
                 snap_ff[ptr_ff];

  // command state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sfsr_pkg::ST_IDLE,
      sfsr_pkg::ST_OPCODE: begin
        if (!cs_act) begin
          nxt_state = sfsr_pkg::ST_IDLE;
        end else if (opc_last) begin
          // no busy check here: status is readable at any time
          if (shift_in == sfsr_pkg::OPC_READ_STATUS) begin
            nxt_state = sfsr_pkg::ST_STATUS;
          end else if (shift_in == sfsr_pkg::OPC_WRITE_STATUS) begin
            nxt_state = sfsr_pkg::ST_WRDATA;
          end else begin
            nxt_state = sfsr_pkg::ST_IGNORE;
          end
        end else begin
          nxt_state = sfsr_pkg::ST_OPCODE;
        end
      end
      sfsr_pkg::ST_WRDATA: begin
        if (!cs_act) begin
          nxt_state = sfsr_pkg::ST_IDLE;
        end else if (data_last) begin
          // further bytes are ignored
          nxt_state = sfsr_pkg::ST_IGNORE;
        end
      end
      sfsr_pkg::ST_STATUS,
      sfsr_pkg::ST_IGNORE: begin
        if (!cs_act) begin
          nxt_state = sfsr_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = sfsr_pkg::ST_IDLE;
      end
    endcase
  end

  // register next values
  always_comb begin
    nxt_lock = lock_ff;
    if (wr_status_end && lock_write_ok) begin
      nxt_lock = new_lock_ff;
    end
    // a set request wins over a clear in the same cycle
    nxt_wel = wel_ff;
    if (wel_set) begin
      nxt_wel = 1'h1;
    end else if (wel_clear || wr_status_end) begin
      nxt_wel = 1'h0;
    end
    if (core_all_protected) begin
      nxt_swp = sfsr_pkg::SWP_ALL;
    end else if (core_any_protected) begin
      nxt_swp = sfsr_pkg::SWP_SOME;
    end else begin
      nxt_swp = sfsr_pkg::SWP_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= sfsr_pkg::ST_IDLE;
      sck_d_ff <= 1'h1; // same level as the synchroniser reset, no false edge
      cs_act_d_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      sck_d_ff <= pins_s.sck;
      cs_act_d_ff <= cs_act;
    end
  end

  // input shifting on rising sck
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= sfsr_pkg::FIRST_BIT;
      shift_ff <= 8'h00;
    end else if (!cs_act) begin
      cnt_ff <= sfsr_pkg::FIRST_BIT;
    end else if (sck_rise) begin
      cnt_ff <= cnt_ff + 3'h1;
      shift_ff <= shift_in;
    end
  end

  // opcode and write-status data capture
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      opc_ff <= 8'h00;
      opc_full_ff <= 1'h0;
      data_full_ff <= 1'h0;
      new_lock_ff <= 1'h0;
      strobe_ff <= 1'h0;
    end else begin
      strobe_ff <= opc_last;
      if (state_ff == sfsr_pkg::ST_IDLE) begin
        opc_full_ff <= 1'h0;
        data_full_ff <= 1'h0;
      end
      if (opc_last) begin
        opc_ff <= shift_in;
        opc_full_ff <= 1'h1;
      end
      if (data_last) begin
        // only bit 7 of the data byte matters
        new_lock_ff <= shift_in[sfsr_pkg::BIT_LOCK];
        data_full_ff <= 1'h1;
      end
    end
  end

  // serial output, changes on falling sck
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ff <= sfsr_pkg::LAST_BIT;
      snap_ff <= '0;
      so_ff <= 1'h0;
      oe_ff <= 1'h0;
    end else if (!in_status) begin
      ptr_ff <= sfsr_pkg::LAST_BIT;
      oe_ff <= 1'h0;
    end else if (shift_out) begin
      so_ff <= out_bit;
      oe_ff <= 1'h1;
      ptr_ff <= ptr_ff - 3'h1;
      if (ptr_ff == sfsr_pkg::LAST_BIT) begin
        snap_ff <= status_ff;
      end
    end
  end

  // status flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_ff <= sfsr_pkg::RST_LOCK;
      wel_ff <= sfsr_pkg::RST_WEL;
      err_ff <= sfsr_pkg::RST_ERR;
      swp_ff <= sfsr_pkg::RST_SWP;
    end else begin
      lock_ff <= nxt_lock;
      wel_ff <= nxt_wel;
      swp_ff <= nxt_swp;
      // aborted operations never pulse op_done
      if (op_done) begin
        err_ff <= op_failed;
      end
    end
  end

  // reset seq_mode and busy follow the core, which is idle in reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= '{lock: sfsr_pkg::RST_LOCK, seq_mode: 1'h0,
                     prog_err: sfsr_pkg::RST_ERR, pin_state: 1'h1,
                     sw_protect_summary: sfsr_pkg::RST_SWP, write_enable_latch: sfsr_pkg::RST_WEL,
                     busy: 1'h0};
    end else begin
      status_ff <= '{lock: lock_ff, seq_mode: core_seq_mode,
                     prog_err: err_ff, pin_state: pins_s.wp_n,
                     sw_protect_summary: swp_ff, write_enable_latch: wel_ff,
                     busy: core_busy};
    end
  end

  // outputs
  assign so_out = so_ff;
  assign so_oe = oe_ff;
  assign status = status_ff;
  assign cmd_opcode = opc_ff;
  assign cmd_strobe = strobe_ff;
  assign write_cmd_enable = wel_ff;
  assign sector_cmd_enable = wel_ff & ~lock_ff;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_status_entry:
    assert property (opc_last && shift_in == sfsr_pkg::OPC_READ_STATUS
                     |=> state_ff == sfsr_pkg::ST_STATUS)
    else $error("read-status opcode did not start output");

  a_busy_read:
    assert property (core_busy && opc_last &&
                     shift_in == sfsr_pkg::OPC_READ_STATUS
                     |=> state_ff == sfsr_pkg::ST_STATUS && status_ff.busy)
    else $error("read-status refused or busy not shown");

  a_bit_wrap:
    assert property (shift_out && ptr_ff == sfsr_pkg::FIRST_BIT
                     |=> ptr_ff == sfsr_pkg::LAST_BIT)
    else $error("status byte did not restart at bit 7");

  a_byte_fresh:
    assert property (shift_out && ptr_ff == sfsr_pkg::LAST_BIT
                     |=> snap_ff == $past(status_ff) && so_out == $past(status_ff.lock))
    else $error("repeated status byte not resampled");

  a_release_float:
    assert property (!cs_act |=> !so_oe)
    else $error("output still driven after select release");

  a_lock_source:
    assert property (lock_ff != $past(lock_ff) |-> $past(wr_status_end))
    else $error("lock changed without write-status");

  a_lock_pin_hold:
    assert property (wp_asserted && lock_ff |=> lock_ff)
    else $error("lock cleared while pin asserted");

  a_err_update:
    assert property (op_done |=> err_ff == $past(op_failed) ##1
                     status_ff.prog_err == $past(err_ff))
    else $error("error flag not refreshed");

  a_err_hold:
    assert property (!op_done |=> err_ff == $past(err_ff))
    else $error("error flag moved without completion");

  a_pin_mirror:
    assert property (status_ff.pin_state == $past(pins_s.wp_n))
    else $error("pin state bit does not mirror pin");

  a_swp_code:
    assert property (status_ff.sw_protect_summary != 2'h2)
    else $error("reserved protection summary code");

  a_sector_gate:
    assert property (sector_cmd_enable |-> wel_ff && !lock_ff)
    else $error("sector commands enabled while locked");

  a_wel_autoclear:
    assert property ((wel_clear || wr_status_end) && !wel_set |=> !wel_ff)
    else $error("write-enable latch did not clear");

  a_wel_partial:
    assert property (cs_end && !opc_full_ff && !wel_set && !wel_clear
                     |=> wel_ff == $past(wel_ff))
    else $error("latch cleared on incomplete opcode");

  c_status_read: cover property (opc_last && shift_in == sfsr_pkg::OPC_READ_STATUS);
  c_byte_wrap: cover property (shift_out && ptr_ff == sfsr_pkg::FIRST_BIT);
  c_lock_set: cover property (wr_status_end && lock_write_ok && new_lock_ff);
  c_mid_byte_end: cover property (cs_end && state_ff == sfsr_pkg::ST_STATUS &&
                                  ptr_ff != sfsr_pkg::LAST_BIT);

endmodule : sfsr_top

// File: testbench/sfsr_host.sv
/*
  sfsr_host: behavioural spi host in modes 0 and 3 for the status register block.
  assumes: core_clk is the bench clock; pins change only at its falling
  edge; each sck phase lasts 4 core cycles (80 ns).
*/
`timescale 1ns/1ps

module sfsr_host (
  // bench clock and clock polarity (1: sck rests high, mode 3)
  input wire logic core_clk,
  input wire logic cpol,
  // device serial out
  input wire logic so_out,
  input wire logic so_oe,
  // host pins
  output logic cs_n,
  output logic sck,
  output logic si
);
  logic oe_seen;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    oe_seen = 1'b1;
  end

  task automatic half_phase;
    repeat (4) @(negedge core_clk);
  endtask : half_phase

  // nsend bits of sdata msb first, then nread bits captured msb first
  task automatic frame(input logic [15:0] sdata, input int nsend, input int nread,
                       output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    oe_seen = 1'b1;
    @(negedge core_clk);
    // resting level settles before select, so no edge lands inside the frame
    sck = cpol;
    repeat (3) @(negedge core_clk);
    cs_n = 1'b0;
    repeat (3) @(negedge core_clk);
    // mode 3: leading fall, ignored by the device
    sck = 1'b0;
    for (i = 0; i < nsend + nread; i++) begin
      if (i < nsend) begin
        si = sdata[15 - i];
      end
      half_phase();
      sck = 1'b1;
      half_phase();
      // sampled late in the high phase: output moves 50 ns after a fall
      if (i >= nsend) begin
        // a floating line reads as the inverse of the held level
        rd = {rd[14:0], so_oe ? so_out : ~so_out};
        oe_seen = oe_seen & so_oe;
      end
      sck = 1'b0;
    end
    half_phase();
    // mode 3: trailing rise back to the resting level
    sck = cpol;
    half_phase();
    cs_n = 1'b1;
    // released line must not keep its last level
    si = ~si;
    repeat (8) @(negedge core_clk);
  endtask : frame
endmodule : sfsr_host

// File: testbench/sfsr_top_test.sv
/*
  sfsr_top_test: self-checking bench for sfsr_top driven by sfsr_host.
  assumes: sfsr_pkg compiled first; design assertions sit in the rtl.
*/
`timescale 1ns/1ps

module sfsr_top_test;
  logic core_clk;
  logic reset_n;
  logic wp_n;
  logic cpol;
  logic cs_n, sck, si, so_out, so_oe;
  logic core_busy, core_seq_mode, core_any_protected, core_all_protected;
  logic op_done, op_failed, wel_set, wel_clear;
  sfsr_pkg::sfsr_pins_t pins;
  sfsr_pkg::sfsr_status_t status;
  logic [7:0] cmd_opcode;
  logic cmd_strobe, write_cmd_enable, sector_cmd_enable;
  logic lock_exp, err_exp, wel_exp;
  logic [15:0] rd;
  logic [7:0] e1;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int strobes = 0;
  // {busy, seq, any, all, wp_n}
  logic [4:0] in_tab [0:4] = '{5'h17, 5'h0F, 5'h05, 5'h01, 5'h06};
  // {wp_n, data byte, lock after}
  logic [9:0] wr_tab [0:4] = '{10'h301, 10'h0FF, 10'h2FE, 10'h1FF, 10'h200};

  assign pins = {cs_n, sck, si, wp_n};

  sfsr_top i_sfsr_top (
    .core_clk(core_clk), .reset_n(reset_n), .pins(pins), .so_out(so_out), .so_oe(so_oe),
    .core_busy(core_busy), .core_seq_mode(core_seq_mode),
    .core_any_protected(core_any_protected), .core_all_protected(core_all_protected),
    .op_done(op_done), .op_failed(op_failed), .wel_set(wel_set), .wel_clear(wel_clear),
    .status(status), .cmd_opcode(cmd_opcode), .cmd_strobe(cmd_strobe),
    .write_cmd_enable(write_cmd_enable), .sector_cmd_enable(sector_cmd_enable)
  );

  sfsr_host i_sfsr_host (
    .core_clk(core_clk), .cpol(cpol), .so_out(so_out), .so_oe(so_oe),
    .cs_n(cs_n), .sck(sck), .si(si)
  );

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (cmd_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end

  // ceiling well above the few thousand cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] exp_status();
    logic [1:0] sw_protect_summary;
    sw_protect_summary = core_all_protected ? sfsr_pkg::SWP_ALL :
          core_any_protected ? sfsr_pkg::SWP_SOME : sfsr_pkg::SWP_NONE;
    return {lock_exp, core_seq_mode, err_exp, wp_n, sw_protect_summary, wel_exp, core_busy};
  endfunction : exp_status

  task automatic core_event(input logic set, input logic clr, input logic done,
                            input logic fail);
    @(negedge core_clk);
    wel_set = set;
    wel_clear = clr;
    op_done = done;
    op_failed = fail;
    @(negedge core_clk);
    wel_set = 1'b0;
    wel_clear = 1'b0;
    op_done = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : core_event

  task automatic read_two;
    i_sfsr_host.frame({sfsr_pkg::OPC_READ_STATUS, 8'h00}, 8, 16, rd);
    check(rd[15:8], exp_status(), "first status byte");
    check(rd[7:0], exp_status(), "repeated status byte");
  endtask : read_two

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic give_verdict;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    cpol = 1'b0;
    wp_n = 1'b1;
    {core_busy, core_seq_mode, core_any_protected, core_all_protected} = 4'h3;
    {op_done, op_failed, wel_set, wel_clear} = 4'h0;
    {lock_exp, err_exp, wel_exp} = 3'h0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check(status, 8'h1C, "status after reset");
    check({7'h00, write_cmd_enable}, 8'h00, "write enable after reset");
    read_two();
    check(cmd_opcode, sfsr_pkg::OPC_READ_STATUS, "opcode seen");
    check(8'(strobes), 8'h01, "one opcode strobe");
    end_test("reset");

    for (int k = 0; k < 5; k++) begin
      @(negedge core_clk);
      {core_busy, core_seq_mode, core_any_protected, core_all_protected, wp_n} = in_tab[k];
      repeat (6) @(negedge core_clk);
      read_two();
    end
    end_test("core fields");

    core_busy = 1'b1;
    wp_n = 1'b1;
    repeat (6) @(negedge core_clk);
    e1 = exp_status();
    fork
      i_sfsr_host.frame({sfsr_pkg::OPC_READ_STATUS, 8'h00}, 8, 16, rd);
      begin
        repeat (100) @(negedge core_clk);
        core_busy = 1'b0;
      end
    join
    check(rd[15:8], e1, "byte before busy falls");
    check(rd[7:0], exp_status(), "byte after busy falls");
    end_test("fresh bytes");

    core_event(1'b1, 1'b0, 1'b0, 1'b0);
    wel_exp = 1'b1;
    check(status, exp_status(), "latch set");
    i_sfsr_host.frame({sfsr_pkg::OPC_WRITE_STATUS, 8'h00}, 4, 0, rd);
    check(status, exp_status(), "half opcode keeps latch");
    check(8'(strobes), 8'h07, "no strobe on half opcode");
    for (int k = 0; k < 5; k++) begin
      @(negedge core_clk);
      wp_n = wr_tab[k][9];
      core_event(1'b1, 1'b0, 1'b0, 1'b0);
      wel_exp = 1'b1;
      check({6'h00, write_cmd_enable, sector_cmd_enable}, {6'h00, 1'b1, ~lock_exp}, "enables");
      i_sfsr_host.frame({sfsr_pkg::OPC_WRITE_STATUS, wr_tab[k][8:1]}, 16, 0, rd);
      lock_exp = wr_tab[k][0];
      wel_exp = 1'b0;
      check(status, exp_status(), "after write status");
    end
    i_sfsr_host.frame({sfsr_pkg::OPC_WRITE_STATUS, 8'h80}, 16, 0, rd);
    check(status, exp_status(), "write without latch ignored");
    end_test("write status");

    core_event(1'b0, 1'b0, 1'b1, 1'b1);
    err_exp = 1'b1;
    check(status, exp_status(), "failed operation");
    core_event(1'b1, 1'b0, 1'b0, 1'b0);
    core_event(1'b0, 1'b1, 1'b0, 1'b0);
    check(status, exp_status(), "abort clears latch only");
    read_two();
    core_event(1'b0, 1'b0, 1'b1, 1'b0);
    err_exp = 1'b0;
    check(status, exp_status(), "good operation");
    end_test("error flag");

    core_event(1'b1, 1'b0, 1'b0, 1'b0);
    i_sfsr_host.frame({sfsr_pkg::OPC_WRITE_STATUS, 8'h80}, 16, 0, rd);
    lock_exp = 1'b1;
    check(status, exp_status(), "lock set before reset");
    reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    lock_exp = 1'b0;
    check(status, exp_status(), "lock and latch after reset");
    end_test("mid reset");

    cpol = 1'b1;
    read_two();
    end_test("mode 3");

    i_sfsr_host.frame({sfsr_pkg::OPC_READ_STATUS, 8'h00}, 8, 3, rd);
    e1 = exp_status();
    check({5'h00, rd[2:0]}, {5'h00, e1[7:5]}, "partial byte");
    check({7'h00, i_sfsr_host.oe_seen}, 8'h01, "output driven in read");
    check({7'h00, so_oe}, 8'h00, "output floats after select");
    end_test("abort read");
    give_verdict();
  end
endmodule : sfsr_top_test
